// ===== arf_pkg.sv
// Constants and the state type for the converter configuration block.
// Assumes the register bus sees one 8-bit location per address.
package arf_pkg;

  // Register addresses
  localparam logic [7:0] ARF_ADDR_CFG = 8'hbc;
  localparam logic [7:0] ARF_ADDR_LOW = 8'hbd;
  localparam logic [7:0] ARF_ADDR_HIGH = 8'hbe;
  localparam logic [7:0] ARF_ADDR_CTL = 8'he8;

  // Field positions in the configuration register
  localparam int ARF_DIV_LSB = 3;
  localparam int ARF_DIV_MSB = 7;
  localparam int ARF_JUST_BIT = 2;
  localparam int ARF_EIGHT_BIT = 1;
  localparam int ARF_GAIN_BIT = 0;

  // Field position in the control register
  localparam int ARF_EN_BIT = 7;

  // Reset values
  localparam logic [7:0] ARF_CFG_RST = 8'hf8;
  localparam logic [7:0] ARF_CTL_RST = 8'h00;
  localparam logic [7:0] ARF_LOW_RST = 8'h00;
  localparam logic [7:0] ARF_HIGH_RST = 8'h00;

  // Widths
  localparam int ARF_DIV_W = 5;
  localparam int ARF_RES_W = 10;

  // All registers of the top module
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctl;
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] rdata;
  } arf_state_t;

endpackage

// ===== arf_sar_clkgen.sv
// Divides the system clock down to the successive-approximation clock.
// Assumes divider and enable come from registers on the same clock.
`timescale 1ns/1ns
module arf_sar_clkgen #(
  parameter int DIV_W = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic enable_i,
  input wire logic [DIV_W-1:0] divider_i,
  // Divided clock
  output logic sar_clk_o
);

  typedef struct packed {
    logic [DIV_W:0] cnt;
    logic clk;
  } arf_div_state_t;

  arf_div_state_t st_r;
  arf_div_state_t st_nxt;
  logic [DIV_W:0] period;
  logic [DIV_W:0] high_len;

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("arf_sar_clkgen: DIV_W out of range");
    end
  end

  // Period is divider plus one; high for the larger half when odd
  assign period = {1'b0, divider_i} + {{DIV_W{1'b0}}, 1'b1};
  assign high_len = (period + {{DIV_W{1'b0}}, 1'b1}) >> 1;

  // clock divide ratio
  // Held low while disabled so the analog core draws no switching power
  always_comb begin
    st_nxt = st_r;
    if (!enable_i) begin
      st_nxt.cnt = '0;
      st_nxt.clk = 1'b0;
    end else begin
      if (st_r.cnt >= {1'b0, divider_i}) begin
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + {{DIV_W{1'b0}}, 1'b1};
      end
      st_nxt.clk = (st_nxt.cnt < high_len);
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sar_clk_o = st_r.clk;

  a_div_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    enable_i && $stable(divider_i) && st_r.cnt == {1'b0, divider_i}
    |=> st_r.cnt == '0)
    else $error("divider counter did not wrap at the programmed value");

endmodule

// ===== arf_result_fmt.sv
// Lays a conversion result out across the high and low data bytes.
// Pure combinational; the caller registers both bytes together.
`timescale 1ns/1ns
module arf_result_fmt #(
  parameter int RES_W = 10
) (
  // Result and mode
  input wire logic [RES_W-1:0] result_i,
  input wire logic eight_bit_i,
  input wire logic justify_i,
  // Formatted bytes
  output logic [7:0] high_o,
  output logic [7:0] low_o
);

  initial begin
    if (RES_W != 10) begin
      $error("arf_result_fmt: only a 10-bit result is supported");
    end
  end

  // Eight-bit mode takes the low byte of the result and ignores justify
  always_comb begin
    if (eight_bit_i) begin
      high_o = result_i[7:0];
      low_o = 8'h00;
    end else if (justify_i) begin
      high_o = result_i[9:2];
      low_o = {result_i[1:0], 6'h00};
    end else begin
      high_o = {6'h00, result_i[9:8]};
      low_o = result_i[7:0];
    end
  end

endmodule

// ===== arf_top.sv
// Converter configuration and result formatting, seen as special-function
// registers. Assumes the analog core and the register bus share clk_i.
//
// Summary of operation
// - SAR clock period equals divider field plus one system clocks.
// - Divider is a five-bit field in bits 7 to 3 of configuration.
// - Justify bit clear places the result right-justified.
// - Justify bit set places the result left-justified.
// - Justify bit only matters in ten-bit mode.
// - Eight-bit bit clear gives ten-bit results, set gives eight-bit.
// - Gain bit in configuration; clear selects gain one half.
// - Right-justified: high byte zeros above two top result bits.
// - Left-justified: high byte holds eight top result bits.
// - Right-justified: low byte holds eight bottom result bits.
// - Left-justified: low byte holds two bottom bits, rest zero.
// - Eight-bit mode: high byte holds eight bottom result bits.
// - Eight-bit mode: low byte reads zero.
// - Enable clear shuts the converter down, set makes it ready.
`timescale 1ns/1ns
module arf_top
  import arf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // Analog core result
  input wire logic conv_done_i,
  input wire logic [ARF_RES_W-1:0] conv_data_i,
  // Analog core control
  output logic converter_enable_o,
  output logic input_gain_select_o,
  output logic eight_bit_mode_enable_o,
  output logic sar_conversion_clock_o
);

  arf_state_t st_r;
  arf_state_t st_nxt;

  logic [7:0] fmt_high;
  logic [7:0] fmt_low;
  logic result_load;
  logic wr_cfg;
  logic wr_ctl;
  logic wr_low;
  logic wr_high;

  // Address decode
  assign wr_cfg = sfr_wr_i && (sfr_addr_i == ARF_ADDR_CFG);
  assign wr_ctl = sfr_wr_i && (sfr_addr_i == ARF_ADDR_CTL);
  assign wr_low = sfr_wr_i && (sfr_addr_i == ARF_ADDR_LOW);
  assign wr_high = sfr_wr_i && (sfr_addr_i == ARF_ADDR_HIGH);

  // results only while enabled
  // A done strobe from a shut-down core is treated as noise
  assign result_load = conv_done_i && st_r.ctl[ARF_EN_BIT];

  // formatter ignores justify in eight-bit mode
  arf_result_fmt #(
    .RES_W(ARF_RES_W)
  ) u_fmt (
    .result_i(conv_data_i),
    .eight_bit_i(st_r.cfg[ARF_EIGHT_BIT]),
    .justify_i(st_r.cfg[ARF_JUST_BIT]),
    .high_o(fmt_high),
    .low_o(fmt_low)
  );

  arf_sar_clkgen #(
    .DIV_W(ARF_DIV_W)
  ) u_clkgen (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(st_r.ctl[ARF_EN_BIT]),
    .divider_i(st_r.cfg[ARF_DIV_MSB:ARF_DIV_LSB]),
    .sar_clk_o(sar_conversion_clock_o)
  );

  // Next-state logic for all registers
  always_comb begin
    st_nxt = st_r;

    // configuration write
    // Divider, justify, mode and gain all live in this one byte
    if (wr_cfg) begin
      st_nxt.cfg = sfr_wdata_i;
    end

    // enable bit write
    // Only the enable bit is kept; the rest of this byte reads zero
    if (wr_ctl) begin
      st_nxt.ctl = sfr_wdata_i & (8'h01 << ARF_EN_BIT);
    end

    if (wr_low) begin
      st_nxt.low = sfr_wdata_i;
    end
    if (wr_high) begin
      st_nxt.high = sfr_wdata_i;
    end

    // both bytes together
    // Placed last so a result landing with a software write wins
    if (result_load) begin
      st_nxt.low = fmt_low;
      st_nxt.high = fmt_high;
    end

    // Read data is captured on the strobe and held until the next one
    if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        ARF_ADDR_CFG: st_nxt.rdata = st_r.cfg;
        ARF_ADDR_CTL: st_nxt.rdata = st_r.ctl;
        ARF_ADDR_LOW: st_nxt.rdata = st_r.low;
        ARF_ADDR_HIGH: st_nxt.rdata = st_r.high;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.cfg <= ARF_CFG_RST;
      st_r.ctl <= ARF_CTL_RST;
      st_r.low <= ARF_LOW_RST;
      st_r.high <= ARF_HIGH_RST;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from registers
  assign sfr_rdata_o = st_r.rdata;
  assign converter_enable_o = st_r.ctl[ARF_EN_BIT];
  // gain select drive
  // Clear selects the half-gain setting of the input amplifier
  assign input_gain_select_o = st_r.cfg[ARF_GAIN_BIT];
  assign eight_bit_mode_enable_o = st_r.cfg[ARF_EIGHT_BIT];

  a_cfg_divider: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_cfg
    |=> st_r.cfg[ARF_DIV_MSB:ARF_DIV_LSB] == $past(sfr_wdata_i[7:3]))
    else $error("divider field not taken from written bits 7 to 3");

  a_right_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && !st_r.cfg[ARF_EIGHT_BIT] && !st_r.cfg[ARF_JUST_BIT]
    |=> st_r.high == {6'h00, $past(conv_data_i[9:8])})
    else $error("right-justified high byte wrong");

  a_right_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && !st_r.cfg[ARF_EIGHT_BIT] && !st_r.cfg[ARF_JUST_BIT]
    |=> st_r.low == $past(conv_data_i[7:0]))
    else $error("right-justified low byte wrong");

  a_left_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && !st_r.cfg[ARF_EIGHT_BIT] && st_r.cfg[ARF_JUST_BIT]
    |=> st_r.high == $past(conv_data_i[9:2]))
    else $error("left-justified high byte wrong");

  a_left_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && !st_r.cfg[ARF_EIGHT_BIT] && st_r.cfg[ARF_JUST_BIT]
    |=> st_r.low == {$past(conv_data_i[1:0]), 6'h00})
    else $error("left-justified low byte wrong");

  a_eight_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && st_r.cfg[ARF_EIGHT_BIT]
    |=> st_r.high == $past(conv_data_i[7:0]))
    else $error("eight-bit high byte wrong");

  a_eight_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load && st_r.cfg[ARF_EIGHT_BIT]
    |=> st_r.low == 8'h00)
    else $error("eight-bit low byte not zero");

  a_off_no_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !converter_enable_o |=> !sar_conversion_clock_o)
    else $error("conversion clock runs while converter is shut down");

  a_off_no_load: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !converter_enable_o && !sfr_wr_i |=> $stable(st_r.high) && $stable(st_r.low))
    else $error("data bytes changed while converter shut down");

  a_sw_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_low && !result_load |=> st_r.low == $past(sfr_wdata_i))
    else $error("software write to low byte lost");

  a_result_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_high && result_load |=> st_r.high == $past(fmt_high))
    else $error("result did not overwrite software write");

  a_mode_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_cfg |=> eight_bit_mode_enable_o == $past(sfr_wdata_i[1]))
    else $error("eight-bit mode output does not follow configuration");

endmodule

// ===== adc_result_format_config_test.sv
// Self-checking bench for the converter configuration and result block.
// Assumes arf_pkg and the arf_top sources are compiled first.
`timescale 1ns/1ns
module adc_result_format_config_test;
  import arf_pkg::*;

  // Design connections, the inputs given a value at time zero
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [ARF_RES_W-1:0] conv_data_i = '0;
  logic [7:0] sfr_rdata_o;
  logic converter_enable_o;
  logic input_gain_select_o;
  logic eight_bit_mode_enable_o;
  logic sar_conversion_clock_o;
  int failures = 0;
  int num_checks = 0;
  int n;
  logic [15:0] exp_w;
  logic [ARF_RES_W-1:0] vals [3] = '{10'h2a5, 10'h3ff, 10'h001};

  // 20 MHz system clock
  always #25 clk_i = ~clk_i;

  arf_top dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_rdata_o(sfr_rdata_o),
    .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i),
    .converter_enable_o(converter_enable_o),
    .input_gain_select_o(input_gain_select_o),
    .eight_bit_mode_enable_o(eight_bit_mode_enable_o),
    .sar_conversion_clock_o(sar_conversion_clock_o)
  );

  // Verdict and end of run, shared by the tests and the watchdog
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; inputs move only at rising edges
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
  endtask

  // Read data is registered at the sampling edge, looked at half a cycle on
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    sfr_rd_i <= 1'b1;
    sfr_addr_i <= a;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(sfr_rdata_o, exp, what);
  endtask

  task automatic conv(input logic [ARF_RES_W-1:0] d);
    @(posedge clk_i);
    conv_done_i <= 1'b1;
    conv_data_i <= d;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
  endtask

  // Reference layout of a result as {high, low}
  function automatic logic [15:0] fmt(input logic [9:0] d, input logic eb, input logic lj);
    if (eb) return {d[7:0], 8'h00};
    if (lj) return {d[9:2], d[1:0], 6'h00};
    return {6'h00, d[9:8], d[7:0]};
  endfunction

  // Waits for a low-to-high step of the divided clock, bounded
  task automatic sar_rise();
    int i;
    logic p;
    p = sar_conversion_clock_o;
    @(negedge clk_i);
    for (i = 0; i < 200; i++) begin
      if (p === 1'b0 && sar_conversion_clock_o === 1'b1) break;
      p = sar_conversion_clock_o;
      @(negedge clk_i);
    end
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    #(50 * 20000);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    time t0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({7'h0, converter_enable_o}, 8'h00, "enable after reset");
    chk({7'h0, sar_conversion_clock_o}, 8'h00, "sar clock after reset");
    rd_chk(ARF_ADDR_CFG, ARF_CFG_RST, "cfg reset");
    rd_chk(ARF_ADDR_LOW, ARF_LOW_RST, "low reset");
    rd_chk(ARF_ADDR_HIGH, ARF_HIGH_RST, "high reset");
    rd_chk(ARF_ADDR_CTL, ARF_CTL_RST, "ctl reset");
    wr_reg(8'h00, 8'h77);
    rd_chk(8'h00, 8'h00, "unmapped read");
    // A result while shut down must leave the data bytes alone
    conv(10'h3ff);
    rd_chk(ARF_ADDR_HIGH, 8'h00, "high after disabled result");
    wr_reg(ARF_ADDR_CFG, 8'h0b);
    rd_chk(ARF_ADDR_CFG, 8'h0b, "cfg readback");
    chk({7'h0, input_gain_select_o}, 8'h01, "gain set");
    chk({7'h0, eight_bit_mode_enable_o}, 8'h01, "eight bit set");
    wr_reg(ARF_ADDR_CFG, 8'h08);
    @(negedge clk_i);
    chk({7'h0, input_gain_select_o}, 8'h00, "gain half");
    chk({7'h0, eight_bit_mode_enable_o}, 8'h00, "ten bit");
    wr_reg(ARF_ADDR_CTL, 8'hff);
    rd_chk(ARF_ADDR_CTL, 8'h80, "ctl readback");
    chk({7'h0, converter_enable_o}, 8'h01, "enable set");
    for (int m = 0; m < 4; m++) begin
      wr_reg(ARF_ADDR_CFG, 8'h08 | 8'(m << 1));
      for (int v = 0; v < 3; v++) begin
        conv(vals[(v + 2) % 3]);
        conv(vals[v]);
        exp_w = fmt(vals[v], m[0], m[1]);
        rd_chk(ARF_ADDR_HIGH, exp_w[15:8], "high format");
        rd_chk(ARF_ADDR_LOW, exp_w[7:0], "low format");
      end
    end
    // Software writes stand until the next result replaces both bytes
    wr_reg(ARF_ADDR_CFG, 8'h08);
    wr_reg(ARF_ADDR_LOW, 8'h5a);
    wr_reg(ARF_ADDR_HIGH, 8'ha5);
    rd_chk(ARF_ADDR_LOW, 8'h5a, "low sw write");
    rd_chk(ARF_ADDR_HIGH, 8'ha5, "high sw write");
    conv(10'h155);
    rd_chk(ARF_ADDR_LOW, 8'h55, "low overwritten");
    rd_chk(ARF_ADDR_HIGH, 8'h01, "high overwritten");
    // period is divider plus one, skipping the wrap after a change
    foreach (vals[k]) begin
      n = (k == 0) ? 1 : (k == 1) ? 3 : 31;
      wr_reg(ARF_ADDR_CFG, 8'(n << ARF_DIV_LSB));
      sar_rise();
      sar_rise();
      t0 = $time;
      sar_rise();
      chk(8'(($time - t0) / 50), 8'(n + 1), "sar period");
    end
    wr_reg(ARF_ADDR_CFG, 8'h00);
    repeat (40) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      chk({7'h0, sar_conversion_clock_o}, 8'h01, "divider zero high");
    end
    wr_reg(ARF_ADDR_CTL, 8'h00);
    repeat (3) @(negedge clk_i);
    chk({7'h0, converter_enable_o}, 8'h00, "enable cleared");
    chk({7'h0, sar_conversion_clock_o}, 8'h00, "sar stopped");
    stop_test();
  end
endmodule
